/* cascade_mux_defs.svh */
/*
 constants for the cascade word-to-byte multiplexer.
 assumes inclusion by bare name from the package; the design does not include it itself.
*/
`ifndef CASCADE_MUX_DEFS_SVH
`define CASCADE_MUX_DEFS_SVH
`define CLK_HZ 20000000
`define BYTES_PER_WORD 4
`define BYTE_BITS 8
`define WORD_BITS 32
`define CMD_BITS 4
`define FIFO_DEPTH 32
`define LINK_MAX_MBPS 100
`define BYTE_CLK_DIV 4
`define SELECT_IDLE 5'h1f
`define SYNC_STAGE 4
`define SYNC_CMD 4'h8
`endif

/* cascade_mux_pkg.sv */
/*
 types shared by the cascade multiplexer.
 assumes the defs header sits in the include path.
*/
`include "cascade_mux_defs.svh"
package cascade_mux_pkg;
	typedef struct packed {
		logic [`WORD_BITS-1:0] data;
		logic [`CMD_BITS-1:0] cmd;
		logic cmd_valid;
	} word_t;
	typedef struct packed {
		logic [`BYTE_BITS-1:0] data;
		logic [`CMD_BITS-1:0] cmd;
		logic strobe;
	} tx_byte_t;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_load = 2'b01,
		st_shift = 2'b10
	} mux_state_t;
endpackage

/* cascade_mux.sv */
/*
 word fifo plus select shifter that feeds a byte-wide serial transmitter.
 assumes the transmitter byte clock comes in on a pin, unsynchronised.
*/
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// fifo
// ----------------------------------------
// plain two-pointer ring; the extra pointer bit tells full from empty.
// out_data is read straight from the array, so a pop sees the word
// in the same cycle as out_valid, with no extra read latency.
// no reset on the array: contents are don't-care until written.
module word_fifo #(
	parameter int WIDTH = 37,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr, rd, next_wr, next_rd;
	logic do_wr, do_rd;
	always_comb begin
		in_ready = (wr[AW] == rd[AW]) || (wr[AW-1:0] != rd[AW-1:0]);
		out_valid = (wr != rd);
		do_wr = in_valid && in_ready;
		do_rd = out_valid && out_ready;
		next_wr = do_wr ? wr + 1'b1 : wr;
		next_rd = do_rd ? rd + 1'b1 : rd;
		out_data = mem[rd[AW-1:0]];
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr <= '0;
			rd <= '0;
		end else begin
			wr <= next_wr;
			rd <= next_rd;
		end
	end
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr[AW-1:0]] <= in_data;
		end
	end
endmodule

// ----------------------------------------
// controller
// ----------------------------------------
module cascade_mux (
	input wire logic clk,
	input wire logic rstn,
	input wire cascade_mux_pkg::word_t word_in,
	input wire logic word_valid,
	output logic word_ready,
	input wire logic tx_byte_clock,
	input wire logic sync_between_words,
	output cascade_mux_pkg::tx_byte_t tx_out,
	output logic [`BYTES_PER_WORD-1:0] register_select_n,
	output logic word_ack_no_sync,
	output logic word_ack_with_sync,
	output logic busy
);
	import cascade_mux_pkg::*;

	localparam int WW = $bits(word_t);
	logic push;
	logic [5:0] occ, next_occ;
	logic next_word_ready;
	word_t fifo_word;
	logic fifo_valid;
	logic pop;

	word_fifo #(.WIDTH(WW), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.in_data(word_in),
		.in_valid(push),
		.in_ready(),
		.out_data(fifo_word),
		.out_valid(fifo_valid),
		.out_ready(pop)
	);

	// ----------------------------------------
	// input occupancy
	// ----------------------------------------
	// mirrors the fifo fill so that word_ready, a flop, is right for the
	// very cycle in which it is shown; a delayed copy of the fifo ready
	// would let a word be pushed into a full fifo and be lost unseen.
	// a push is only taken while word_ready is high.
	always_comb begin
		push = word_valid && word_ready;
		next_occ = occ;
		if (push && !pop) begin
			next_occ = occ + 6'h01;
		end else if (!push && pop) begin
			next_occ = occ - 6'h01;
		end
		next_word_ready = (next_occ < 6'(`FIFO_DEPTH));
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			occ <= 6'h00;
		end else begin
			occ <= next_occ;
		end
	end

	// ----------------------------------------
	// byte clock sampling
	// ----------------------------------------
	// the byte clock is foreign to clk: two flops settle it, a third
	// keeps the previous level for edge detection. costs three cycles
	// of latency from pin edge to strobe, far below one byte time.
	// reset level matches the idle low pin, so no false edge follows.
	logic [2:0] bclk_sync, next_bclk_sync;
	logic bclk_rise, bclk_fall;
	always_comb begin
		next_bclk_sync = {bclk_sync[1:0], tx_byte_clock};
		bclk_rise = bclk_sync[1] && !bclk_sync[2];
		bclk_fall = !bclk_sync[1] && bclk_sync[2];
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bclk_sync <= 3'h0;
		end else begin
			bclk_sync <= next_bclk_sync;
		end
	end

	// ----------------------------------------
	// select shifter
	// ----------------------------------------
	// byte order matches the receiver chain, primary first
	function automatic logic [`BYTE_BITS-1:0] pick_byte(input word_t w, input logic [4:0] sel);
		logic [`BYTE_BITS-1:0] b;
		b = 8'h00;
		for (int i = 0; i < `BYTES_PER_WORD; i++) begin
			if (!sel[i]) begin
				b = w.data[i*`BYTE_BITS +: `BYTE_BITS];
			end
		end
		return b;
	endfunction

	// command nibble for the selected stage; the sync stage carries the marker
	function automatic logic [`CMD_BITS-1:0] pick_cmd(input word_t w, input logic [4:0] sel);
		logic [`CMD_BITS-1:0] c;
		c = 4'h0;
		if (sel[3:0] == 4'hf) begin
			c = `SYNC_CMD;
		end else if (w.cmd_valid && !sel[3]) begin
			c = w.cmd;
		end
		return c;
	endfunction

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// idle pops one word and presets the single zero; load waits for a
	// falling byte clock so that the first strobe comes on a whole high
	// phase; shift strobes on rises and moves the zero on falls.
	// the strobe is a synchronous pulse, never the raw gated clock,
	// so no gating transient can reach the transmitter.
	mux_state_t state, next_state;
	logic [4:0] sel, next_sel;
	word_t held, next_held;
	tx_byte_t next_tx;
	logic next_word_ack_no_sync, next_word_ack_with_sync;
	logic stage_active;
	always_comb begin
		next_state = state;
		next_sel = sel;
		next_held = held;
		next_tx = tx_out;
		next_word_ack_no_sync = 1'b0;
		next_word_ack_with_sync = 1'b0;
		pop = 1'b0;
		stage_active = (sel[3:0] != 4'hf) || (!sel[`SYNC_STAGE] && sync_between_words);
		unique case (state)
			st_idle: begin
				next_tx.strobe = 1'b0;
				if (fifo_valid) begin
					// load only when idle; words wait in the fifo meanwhile
					pop = 1'b1;
					next_held = fifo_word; // all bytes captured at once
					next_sel = 5'h1e; // zero preset while load strobe high
					next_state = st_load;
				end
			end
			st_load: begin
				if (bclk_fall) begin
					next_state = st_shift;
				end
			end
			st_shift: begin
				// strobe only on rising clock when a stage is selected
				next_tx.strobe = bclk_rise && stage_active;
				if (bclk_rise && stage_active) begin
					next_tx.data = (sel[3:0] != 4'hf) ? pick_byte(held, sel) : 8'h00;
					// commands muxed with data; low on the first three data bytes, cmd on the fourth when cmd_valid
					next_tx.cmd = pick_cmd(held, sel); // sync on stage 5
				end
				if (bclk_fall) begin
					// advance on falling clock, after strobe
					// stage one input forced high keeps one zero
					next_sel = {sel[3:0], 1'b1};
					next_word_ack_no_sync = !sel[3];
					next_word_ack_with_sync = !sel[`SYNC_STAGE];
					if ((!sel[3] && !sync_between_words) || !sel[`SYNC_STAGE]) begin
						next_sel = `SELECT_IDLE;
						next_state = st_idle;
					end
				end
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// every output leaves from a flop; acks are one-cycle pulses and
	// word_ready is already correct for the cycle in which it stands.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= st_idle;
			sel <= `SELECT_IDLE;
			held <= '0;
			tx_out <= '0;
			word_ack_no_sync <= 1'b0;
			word_ack_with_sync <= 1'b0;
			register_select_n <= 4'hf;
			busy <= 1'b0;
			word_ready <= 1'b0;
		end else begin
			state <= next_state;
			sel <= next_sel;
			held <= next_held;
			tx_out <= next_tx;
			word_ack_no_sync <= next_word_ack_no_sync;
			word_ack_with_sync <= next_word_ack_with_sync;
			register_select_n <= next_sel[3:0];
			busy <= (next_state != st_idle);
			word_ready <= next_word_ready;
		end
	end
endmodule
`default_nettype wire

/* cascade_mux_monitor.sv */
/*
 port checker for the cascade multiplexer.
 assumes one clock domain and bind by the footer.
*/
`timescale 1ns/100ps
`default_nettype none
module cascade_mux_monitor (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tx_byte_clock,
	input wire logic sync_between_words,
	input wire cascade_mux_pkg::tx_byte_t tx_out,
	input wire logic [3:0] register_select_n,
	input wire logic word_ack_no_sync,
	input wire logic word_ack_with_sync,
	input wire logic busy
);
	import cascade_mux_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// strobe follows a sampled rise through two syncs and a register
	sequence late_rise;
		$past(tx_byte_clock, 3) || $past(tx_byte_clock, 4);
	endsequence
	one_zero_a: assert property ($onehot0(~register_select_n)) else $error("two selects");
	strobe_rise_a: assert property (tx_out.strobe |-> late_rise) else $error("strobe off rise");
	strobe_pulse_a: assert property (tx_out.strobe |=> !tx_out.strobe) else $error("long strobe");
	strobe_busy_a: assert property (tx_out.strobe |-> busy) else $error("idle strobe");
	select_steady_a: assert property (tx_out.strobe |-> $stable(register_select_n))
		else $error("select moved at strobe");
	cmd_low_a: assert property (tx_out.strobe && register_select_n != 4'h7 |->
		tx_out.cmd == 4'h0 || (tx_out.cmd == 4'h8 && tx_out.data == 8'h00))
		else $error("stray command bits");
	ack_kind_a: assert property (word_ack_with_sync |-> sync_between_words && !word_ack_no_sync)
		else $error("wrong ack");
	ack_end_a: assert property (word_ack_no_sync || word_ack_with_sync |=> !tx_out.strobe)
		else $error("strobe after ack");
endmodule
bind cascade_mux cascade_mux_monitor mon (.clk(clk), .rstn(rstn), .tx_byte_clock(tx_byte_clock),
	.sync_between_words(sync_between_words), .tx_out(tx_out),
	.register_select_n(register_select_n), .word_ack_no_sync(word_ack_no_sync),
	.word_ack_with_sync(word_ack_with_sync), .busy(busy));
`default_nettype wire

/* tx_model.sv */
/*
 transmitter and receiver chain model.
 assumes a free running byte clock, as the transmitter gives.
*/
`timescale 1ns/100ps
`default_nettype none
module tx_model (
	input wire logic clk,
	input wire cascade_mux_pkg::tx_byte_t tx_out,
	output logic tx_byte_clock,
	output logic [31:0] word_seen,
	output logic [3:0] cmd_seen
);
	import cascade_mux_pkg::*;
	int ph = 0;
	logic [1:0] slot = 2'h0;
	initial tx_byte_clock = 1'b0;
	initial word_seen = 32'h0;
	initial cmd_seen = 4'h0;
	always @(posedge clk) begin
		ph <= (ph + 1) % 8; // byte rate far below the link cap
		tx_byte_clock <= (ph >= 3);
		if (tx_out.strobe === 1'b1) begin // every strobe but a sync becomes a byte
			if (tx_out.cmd == 4'h8) begin
				slot <= 2'h0; // sync rearms the chain
			end else begin
				word_seen[slot*8 +: 8] <= tx_out.data; // chain order
				if (slot == 2'h3) begin
					cmd_seen <= tx_out.cmd;
				end
				slot <= slot + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* cascade_mux_test.sv */
/*
 scenario bench for the cascade multiplexer.
 assumes the model in tx_model.sv.
*/
`timescale 1ns/100ps
`default_nettype none
module cascade_mux_test;
	import cascade_mux_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, word_valid = 1'b0, sync_between_words = 1'b1;
	word_t word_in = '0;
	logic tx_byte_clock, word_ready, word_ack_no_sync, word_ack_with_sync, busy;
	tx_byte_t tx_out;
	logic [3:0] register_select_n, cmd_seen;
	logic [31:0] word_seen;
	int errors = 0, check_count = 0, cycles = 0;
	always #25 clk = ~clk;
	cascade_mux dut (.clk(clk), .rstn(rstn), .word_in(word_in), .word_valid(word_valid),
		.word_ready(word_ready), .tx_byte_clock(tx_byte_clock),
		.sync_between_words(sync_between_words), .tx_out(tx_out),
		.register_select_n(register_select_n), .word_ack_no_sync(word_ack_no_sync),
		.word_ack_with_sync(word_ack_with_sync), .busy(busy));
	tx_model far (.clk(clk), .tx_out(tx_out), .tx_byte_clock(tx_byte_clock),
		.word_seen(word_seen), .cmd_seen(cmd_seen));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		if (errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end
	task automatic send_word(input logic [31:0] d, input logic [3:0] c, input logic s);
		int n;
		n = 0;
		@(posedge clk);
		sync_between_words <= s;
		word_in <= '{d, c, 1'b1};
		word_valid <= 1'b1;
		@(negedge clk);
		while (word_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		word_valid <= 1'b0;
		// with a sync the no-sync ack comes first, one stage early
		while ((s ? word_ack_with_sync : word_ack_no_sync) !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		check("ack kind", word_ack_with_sync, s);
		check("ack plain", word_ack_no_sync, !s);
		check("word", word_seen, d);
		check("command", cmd_seen, c);
	endtask
	// pushes until refused, then lets the slow far side drain it all
	task automatic fill_drain;
		int n, quiet;
		n = 0;
		quiet = 0;
		@(posedge clk);
		word_in <= '{32'h0, 4'h0, 1'b0};
		word_valid <= 1'b1;
		@(negedge clk);
		while (word_ready === 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		check("full refuses", word_ready, 1'b0);
		@(posedge clk);
		word_valid <= 1'b0;
		n = 0;
		while (quiet < 30 && n < 5000) begin
			@(negedge clk);
			n++;
			quiet = (busy === 1'b0) ? quiet + 1 : 0;
		end
		check("drained", {word_ready, busy}, 2'b10);
		check("last word", word_seen, 32'h0);
	endtask
	task automatic reset_run;
		rstn <= 1'b0;
		repeat (10) @(posedge clk);
		check("select idle", register_select_n, 4'hf);
		check("reset outputs", {word_ready, busy, tx_out.strobe}, 3'b000);
		rstn <= 1'b1;
	endtask
	initial begin
		reset_run();
		send_word(32'h44332211, 4'h5, 1'b1);
		send_word(32'ha5c30ff0, 4'h3, 1'b0);
		send_word(32'h01020304, 4'h0, 1'b1);
		fill_drain();
		summarize();
	end
endmodule
`default_nettype wire
